/* core/sep_pkg.sv */
// shared constants, types and state record of the serial memory slave
package sep_pkg;

  // ----------------------------------------------------------------
  // select byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_CODE      = 4'hA;   // fixed bits 1,0,1,0
  localparam logic [3:0] BIT_LAST      = 4'h8;   // eighth data clock
  localparam logic [3:0] BIT_ACK       = 4'h9;   // ninth, acknowledge clock
  localparam logic [7:0] ERASE_ADDR    = 8'h00;  // address that arms full erase
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;  // erased cell pattern

  // ----------------------------------------------------------------
  // programming times
  // ----------------------------------------------------------------
  localparam int CLK_KHZ       = 125000;        // 125 MHz system clock
  localparam int PROG_TIME_MS  = 20;            // erase plus write, longest
  localparam int ERASE_TIME_MS = 20;            // whole array erase, longest
  localparam int PROG_CYC      = PROG_TIME_MS * CLK_KHZ;   // rounded down
  localparam int ERASE_CYC     = ERASE_TIME_MS * CLK_KHZ;  // rounded down
  localparam int CNT_W         = 22;            // holds 2.5 million

  // ----------------------------------------------------------------
  // avalon register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL     = 4'h0;  // bit0 slave enable
  localparam logic [3:0]  REG_STATUS   = 4'h4;  // busy, erase, address
  localparam logic        CTRL_EN_RST  = 1'h1;  // slave answers after reset
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_ERASE_BIT = 1;
  localparam int          ST_ADDR_LSB  = 8;

  // ----------------------------------------------------------------
  // byte sequencer states, gray along idle-select-address-data
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEP_IDLE   = 3'h0,
    SEP_SELECT = 3'h1,
    SEP_ADDR   = 3'h3,
    SEP_WDATA  = 3'h2,
    SEP_RDATA  = 3'h6,
    SEP_IGNORE = 3'h7
  } sep_state_t;

  // synchronised pin group
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [2:0] select_bits;      // strap levels select_bit_2..0
    logic       select_bit_2_open; // total erase strap condition
  } sep_pins_t;

  // whole state of the slave
  typedef struct packed {
    sep_state_t        state;
    sep_state_t        nst;       // state after the ack clock
    logic              scl_q;
    logic              sda_q;
    logic [3:0]        bitcnt;
    logic [7:0]        shreg;
    logic [7:0]        addr;
    logic [7:0]        data;
    logic              pend;      // complete write, waiting for stop
    logic              busy;
    logic              erase_all;
    logic [CNT_W-1:0]  cnt;
    logic              sda_oe;
    logic              sda_out;
    logic              enable;
    logic              avs_wait;
    logic [31:0]       rdata;
  } sep_state_rec_t;

endpackage

/* core/sep_sync.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module sep_sync #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;  // first stage, read only by second stage

  // ----------------------------------------------------------------
  // two stages, pins idle high like the bus
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      meta_ff <= '1;
      o_sync  <= '1;
    end
    else
    begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end

endmodule // sep_sync

/* core/sep_core.sv */
// two-wire 256x8 nonvolatile memory slave with avalon status port
//
// Summary of operation
// - write-select 1010+selects+0, memory acks clock nine
// - read-select has last bit 1, then transmit
// - address byte msb first, acked clock nine
// - write data msb first, acked clock nine
// - read data msb first, released clock nine
// - word program finishes within 20 ms
// - full erase finishes within 20 ms
// - selected only when select bits match straps
// - stop after 27 clocks starts programming
// - write-select aborts programming, read-select ignored
// - master ack low increments address, wraps
`timescale 1ns/100ps
module sep_core #(
  parameter int P_PROG_CYC  = sep_pkg::PROG_CYC,   // word program cycles
  parameter int P_ERASE_CYC = sep_pkg::ERASE_CYC   // full erase cycles
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic [2:0]  i_select_bits,
  input  wire logic        i_select_bit_2_open,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  import sep_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sep_pins_t        pins_raw;     // pins straight from outside
  sep_pins_t        pins;         // pins after two flops
  sep_state_rec_t   s_ff;         // registered state
  sep_state_rec_t   nxt_s;        // next state
  logic [7:0]       mem [256];    // the array itself
  logic [7:0]       mem_rd;       // byte at current address
  logic             mem_we;       // array write strobe
  logic [7:0]       mem_wa;       // array write address
  logic [7:0]       mem_wd;       // array write data
  logic             scl_rise;
  logic             scl_fall;
  logic             start_evt;
  logic             stop_evt;
  logic             sel_match;    // select byte addresses this chip
  logic [CNT_W-1:0] prog_last;    // last cycle of current program

  assign pins_raw = '{scl: i_scl, sda: i_sda, select_bits: i_select_bits,
                      select_bit_2_open: i_select_bit_2_open};

  sep_sync #(.W($bits(sep_pins_t))) u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async (pins_raw),
    .o_sync  (pins)
  );

  // ----------------------------------------------------------------
  // bus events, all on synchronised levels
  // ----------------------------------------------------------------
  assign scl_rise  = pins.scl & ~s_ff.scl_q;
  assign scl_fall  = ~pins.scl & s_ff.scl_q;
  assign start_evt = pins.scl & s_ff.scl_q & s_ff.sda_q & ~pins.sda;
  assign stop_evt  = pins.scl & s_ff.scl_q & ~s_ff.sda_q & pins.sda;
  assign sel_match = (s_ff.shreg[7:4] == DEV_CODE)
                   & (s_ff.shreg[3:1] == pins.select_bits) & s_ff.enable;
  assign mem_rd    = mem[s_ff.addr];
  // erase and program share one timer, lengths may differ
  assign prog_last = s_ff.erase_all ? CNT_W'(P_ERASE_CYC - 1)
                                    : CNT_W'(P_PROG_CYC - 1);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s       = s_ff;
    mem_we      = 1'b0;
    mem_wa      = s_ff.addr;
    mem_wd      = s_ff.data;
    nxt_s.scl_q = pins.scl;
    nxt_s.sda_q = pins.sda;

    // programming timer
    if (s_ff.busy)
    begin
      nxt_s.cnt = s_ff.cnt + CNT_W'(1);
      if (s_ff.erase_all)
      begin
        mem_we = 1'b1;
        mem_wa = s_ff.cnt[7:0];
        mem_wd = ERASED_BYTE;
      end
      if (s_ff.cnt == prog_last)
      begin
        nxt_s.busy = 1'b0;
        mem_we     = 1'b1;
      end
    end

    if (start_evt)
    begin
      // any start, repeated or not, reopens select
      nxt_s.state  = SEP_SELECT;
      nxt_s.bitcnt = '0;
      nxt_s.sda_oe = 1'b0;
      nxt_s.pend   = 1'b0;
    end
    else if (stop_evt)
    begin
      nxt_s.state  = SEP_IDLE;
      nxt_s.sda_oe = 1'b0;
      nxt_s.pend   = 1'b0;
      if (s_ff.pend)
      begin
        nxt_s.busy      = 1'b1;
        nxt_s.cnt       = '0;
        nxt_s.erase_all = pins.select_bit_2_open & (s_ff.addr == ERASE_ADDR)
                        & (s_ff.data == ERASED_BYTE);
      end
    end
    else if (scl_rise)
    begin
      if (s_ff.bitcnt < BIT_LAST)
      begin
        nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
        if (s_ff.state != SEP_RDATA)
          nxt_s.shreg = {s_ff.shreg[6:0], pins.sda};
      end
      else if (s_ff.bitcnt == BIT_ACK && s_ff.state == SEP_RDATA)
      begin
        if (!pins.sda)
        begin
          nxt_s.addr = s_ff.addr + 8'h01;
          nxt_s.nst  = SEP_RDATA;
        end
        else
          nxt_s.nst = SEP_IGNORE;
      end
    end
    else if (scl_fall)
    begin
      if (s_ff.bitcnt == BIT_LAST)
      begin
        // ack clock begins: decide who holds the line
        nxt_s.bitcnt = BIT_ACK;
        nxt_s.sda_oe = 1'b0;
        nxt_s.nst    = s_ff.state;
        case (s_ff.state)
          SEP_SELECT:
          begin
            if (!sel_match)
              nxt_s.nst = SEP_IGNORE;
            else if (!s_ff.shreg[0])
            begin
              nxt_s.sda_oe = 1'b1;
              nxt_s.nst    = SEP_ADDR;
              nxt_s.busy   = 1'b0;
            end
            else if (s_ff.busy)
              nxt_s.nst = SEP_IGNORE;
            else
            begin
              nxt_s.sda_oe = 1'b1;
              nxt_s.nst    = SEP_RDATA;
            end
          end
          SEP_ADDR:
          begin
            nxt_s.addr   = s_ff.shreg;
            nxt_s.sda_oe = 1'b1;
            nxt_s.nst    = SEP_WDATA;
          end
          SEP_WDATA:
          begin
            nxt_s.data   = s_ff.shreg;
            nxt_s.sda_oe = 1'b1;
            nxt_s.pend   = 1'b1;
            nxt_s.nst    = SEP_IGNORE;
          end
          default:
            nxt_s.nst = s_ff.state;
        endcase
      end
      else if (s_ff.bitcnt == BIT_ACK)
      begin
        // ack clock over: move on, load read byte
        nxt_s.bitcnt = '0;
        nxt_s.state  = s_ff.nst;
        nxt_s.sda_oe = 1'b0;
        if (s_ff.nst == SEP_RDATA)
        begin
          nxt_s.shreg  = mem_rd;
          nxt_s.sda_oe = ~mem_rd[7];
        end
      end
      else if (s_ff.state == SEP_RDATA && s_ff.bitcnt != 4'h0)
      begin
        // next bit, open drain pulls only zeros
        nxt_s.shreg  = {s_ff.shreg[6:0], 1'b0};
        nxt_s.sda_oe = ~s_ff.shreg[6];
      end
    end

    // avalon slave: one wait cycle, then answer for one cycle
    nxt_s.avs_wait = 1'b1;
    if ((i_avs_read | i_avs_write) && s_ff.avs_wait)
    begin
      nxt_s.avs_wait = 1'b0;
      nxt_s.rdata    = '0;
      if (i_avs_address == REG_CTRL)
        nxt_s.rdata[0] = s_ff.enable;
      else if (i_avs_address == REG_STATUS)
      begin
        nxt_s.rdata[ST_BUSY_BIT]               = s_ff.busy;
        nxt_s.rdata[ST_ERASE_BIT]              = s_ff.busy & s_ff.erase_all; // cleared with busy after sweep, erase_all stays set
        nxt_s.rdata[ST_ADDR_LSB +: 8]          = s_ff.addr;
      end
    end
    if (i_avs_write && !s_ff.avs_wait && i_avs_address == REG_CTRL)
      nxt_s.enable = i_avs_writedata[0];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      s_ff          <= '0;
      s_ff.scl_q    <= 1'b1;
      s_ff.sda_q    <= 1'b1;
      s_ff.enable   <= CTRL_EN_RST;
      s_ff.avs_wait <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // array, not reset: contents are nonvolatile
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign o_sda_out         = s_ff.sda_out;
  assign o_sda_oe          = s_ff.sda_oe;
  assign o_avs_readdata    = s_ff.rdata;
  assign o_avs_waitrequest = s_ff.avs_wait;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  wsel_ack_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_SELECT && sel_match && !s_ff.shreg[0] |=> o_sda_oe)
    else $error("write select not acknowledged");
  rsel_ack_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_SELECT && sel_match && s_ff.shreg[0] && !s_ff.busy
    |=> o_sda_oe && s_ff.nst == SEP_RDATA)
    else $error("read select not acknowledged");
  addr_take_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_ADDR |=> o_sda_oe && s_ff.addr == $past(s_ff.shreg))
    else $error("address byte not taken");
  data_take_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_WDATA |=> o_sda_oe && s_ff.pend
    && s_ff.data == $past(s_ff.shreg))
    else $error("data byte not taken");
  read_release_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_RDATA |=> !o_sda_oe)
    else $error("line held in master ack clock");
  prog_bound_a: assert property (s_ff.busy |-> s_ff.cnt <= prog_last)
    else $error("program timer overran");
  erase_fill_a: assert property (s_ff.busy && s_ff.erase_all
    |-> mem_we && mem_wd == ERASED_BYTE)
    else $error("full erase not writing erased cells");
  nomatch_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_SELECT && !sel_match |=> !o_sda_oe)
    else $error("acked a foreign select");
  stop_prog_a: assert property (stop_evt && s_ff.pend
    |=> s_ff.busy && s_ff.cnt == '0)
    else $error("stop did not start programming");
  busy_ignore_a: assert property (scl_fall && s_ff.bitcnt == BIT_LAST
    && s_ff.state == SEP_SELECT && sel_match && s_ff.shreg[0] && s_ff.busy
    |=> !o_sda_oe && s_ff.nst == SEP_IGNORE)
    else $error("read select answered while busy");
  addr_step_a: assert property (scl_rise && s_ff.bitcnt == BIT_ACK
    && s_ff.state == SEP_RDATA && !pins.sda && !start_evt && !stop_evt
    |=> s_ff.addr == $past(s_ff.addr) + 8'h01)
    else $error("read address not stepped");
  ignore_quiet_a: assert property (s_ff.state == SEP_IGNORE
    |-> !o_sda_oe)
    else $error("line driven while ignoring");
  avs_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer stood longer than one cycle");

  prog_done_c:  cover property (s_ff.busy ##1 !s_ff.busy);
  read_next_c:  cover property (s_ff.state == SEP_RDATA && scl_rise
                                && s_ff.bitcnt == BIT_ACK && !pins.sda);
  abort_c:      cover property (s_ff.busy && scl_fall && s_ff.bitcnt == BIT_LAST
                                && s_ff.state == SEP_SELECT && sel_match
                                && !s_ff.shreg[0]);
  erase_all_c:  cover property (s_ff.busy && s_ff.erase_all);

endmodule // sep_core

/* bench/sep_master_model.sv */
// two-wire bus master model that drives the serial memory slave
`timescale 1ns/100ps
module sep_master_model (
  output logic      o_scl,
  output logic      o_sda_drv,
  input  wire logic i_sda_wire
);
  logic [8:0] got;    // last byte on the wire plus its ninth bit
  event       got_ev; // fires once a whole byte has passed

  // ------------------------------------------------------------
  // idle bus: both lines released high
  // ------------------------------------------------------------
  initial
  begin
    o_scl     = 1'b1;
    o_sda_drv = 1'b1;
  end

  // one clock, 64 ns; tasks start on a system clock edge and every
  // line change lands 2 ns after an edge, so no change races a sample
  task automatic clk_bit(input logic b, output logic r);
    #2 o_sda_drv = b;
    #24 o_scl = 1'b1;
    // sampled late in the high phase, after the slave's sync delay
    #24 r = i_sda_wire;
    #8 o_scl = 1'b0;
    #6;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_c();
    #2 o_sda_drv = 1'b1;
    #24 o_scl = 1'b1;
    #32 o_sda_drv = 1'b0;
    #32 o_scl = 1'b0;
    #6;
  endtask

  // stop: data rises while the clock is high, bus left idle
  task automatic stop_c();
    #2 o_sda_drv = 1'b0;
    #24 o_scl = 1'b1;
    #32 o_sda_drv = 1'b1;
    #38;
  endtask

  // eight data clocks msb first, then the ninth clock; ack 1 releases
  task automatic byte_c(input logic [7:0] d, input logic ack);
    logic r;
    for (int i = 8; i >= 0; i--)
    begin
      clk_bit((i > 0) ? d[i-1] : ack, r);
      got[i] = r;
    end
    ->got_ev;
  endtask
endmodule // sep_master_model

/* bench/tb_sep_core.sv */
// self-checking bench of the serial memory slave
`timescale 1ns/100ps
module tb_sep_core;
  import sep_pkg::*;

  typedef struct packed {
    logic [31:0] val;
    logic [31:0] mask;
  } sep_note_t;

  logic        i_mclk, i_rst, scl, sda_drv, sda_out, sda_oe, strap_open;
  logic [2:0]  straps;                    // select strap levels
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, waitreq;
  logic [31:0] avs_writedata, rdata, rng;
  logic [7:0]  d0, d1;
  wire         sda_wire = sda_drv & ~(sda_oe & ~sda_out); // pull-up wire
  sep_note_t   bus_q[$];                  // expected register reads
  logic [8:0]  link_q[$];                 // expected bytes on the wire
  int          err_total, total_checks;

  sep_core #(.P_PROG_CYC(300), .P_ERASE_CYC(300)) i_sep_core (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_select_bits(straps),
    .i_select_bit_2_open(strap_open), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq));

  sep_master_model i_sep_master_model (
    .o_scl(scl), .o_sda_drv(sda_drv), .i_sda_wire(sda_wire));

  // ------------------------------------------------------------
  // clock, comparison and verdict
  // ------------------------------------------------------------
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [7:0] sel(input logic rw, input logic [2:0] s);
    return {DEV_CODE, s, rw};
  endfunction

  // ------------------------------------------------------------
  // watchers: oldest note against each result that appears
  // ------------------------------------------------------------
  // note taken off first: argument order must not decide the compare
  always @(posedge i_mclk)
  begin : bus_watch
    sep_note_t nb;
    if (avs_read === 1'b1 && waitreq === 1'b0 && bus_q.size() > 0)
    begin
      nb = bus_q.pop_front();
      check("avs_readdata", rdata & nb.mask, nb.val);
    end
  end

  always @(i_sep_master_model.got_ev)
    if (link_q.size() > 0)
      check("link_byte", {23'h0, i_sep_master_model.got}, {23'h0, link_q.pop_front()});

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  // one avalon access; an edge passes first so a request never follows a release
  task automatic bus(input logic [3:0] adr, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge i_mclk);
    avs_address   <= adr;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= wd;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rd = rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
      err_total++;
  endtask

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] v, input logic [31:0] m);
    logic [31:0] x;
    bus_q.push_back('{val: v, mask: m});
    bus(adr, 1'b0, 32'h0, x);
  endtask

  task automatic lb(input logic [7:0] d, input logic ack, input logic [8:0] exp);
    link_q.push_back(exp);
    i_sep_master_model.byte_c(d, ack);
  endtask

  // bounded wait for the end of programming or erase
  task automatic wait_idle();
    logic [31:0] st;
    int n;
    n = 0;
    do
    begin
      bus(REG_STATUS, 1'b0, 32'h0, st);
      n++;
    end while (st[1:0] !== 2'b00 && n < 300);
    rd_chk(REG_STATUS, 32'h0, 32'h3);
  endtask

  // start, select, address and data (27 clocks); the caller sends the stop
  task automatic wr_word(input logic [7:0] a, input logic [7:0] d);
    i_sep_master_model.start_c();
    lb(sel(1'b0, straps), 1'b1, {sel(1'b0, straps), 1'b0});
    lb(a, 1'b1, {a, 1'b0});
    lb(d, 1'b1, {d, 1'b0});
  endtask

  // random read of two words across the address wrap
  task automatic rd_two(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    i_sep_master_model.start_c();
    lb(sel(1'b0, straps), 1'b1, {sel(1'b0, straps), 1'b0});
    lb(a, 1'b1, {a, 1'b0});
    i_sep_master_model.start_c();
    lb(sel(1'b1, straps), 1'b1, {sel(1'b1, straps), 1'b0});
    lb(8'hFF, 1'b0, {e0, 1'b0});
    lb(8'hFF, 1'b1, {e1, 1'b1});
    i_sep_master_model.stop_c();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] x;
    i_rst = 1'b1;
    strap_open = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    total_checks = 0;
    rng = 32'h0000003B;
    x = xs();
    straps = x[2:0];
    d0 = x[15:8];
    d1 = x[23:16];
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    // reset values, unmapped place reads zero and ignores writes
    rd_chk(REG_CTRL, 32'h1, 32'hFFFFFFFF);
    rd_chk(REG_STATUS, 32'h0, 32'h3);
    bus(4'h8, 1'b1, 32'hFFFFFFFF, x);
    rd_chk(4'h8, 32'h0, 32'hFFFFFFFF);
    // last address, then poll with a read select while busy
    wr_word(8'hFF, d0);
    i_sep_master_model.stop_c();
    i_sep_master_model.start_c();
    lb(sel(1'b1, straps), 1'b1, {sel(1'b1, straps), 1'b1});
    i_sep_master_model.stop_c();
    rd_chk(REG_STATUS, 32'h1, 32'h1);
    wait_idle();
    wr_word(8'h00, d1);
    i_sep_master_model.stop_c();
    wait_idle();
    rd_two(8'hFF, d0, d1);
    // programming cut short by a write select keeps the old word
    wr_word(8'h00, ~d1);
    i_sep_master_model.stop_c();
    i_sep_master_model.start_c();
    lb(sel(1'b0, straps), 1'b1, {sel(1'b0, straps), 1'b0});
    i_sep_master_model.stop_c();
    rd_chk(REG_STATUS, 32'h0, 32'h1);
    rd_two(8'hFF, d0, d1);
    // wrong select bits: no ack, following byte ignored
    i_sep_master_model.start_c();
    lb(sel(1'b0, ~straps), 1'b1, {sel(1'b0, ~straps), 1'b1});
    lb(8'h00, 1'b1, 9'h001);
    i_sep_master_model.stop_c();
    // slave disabled never acknowledges
    bus(REG_CTRL, 1'b1, 32'h0, x);
    i_sep_master_model.start_c();
    lb(sel(1'b0, straps), 1'b1, {sel(1'b0, straps), 1'b1});
    i_sep_master_model.stop_c();
    bus(REG_CTRL, 1'b1, 32'h1, x);
    rd_chk(REG_CTRL, 32'h1, 32'h1);
    // full erase armed by the open strap at stop
    wr_word(8'h00, 8'hFF);
    @(posedge i_mclk);
    strap_open <= 1'b1;
    i_sep_master_model.stop_c();
    rd_chk(REG_STATUS, 32'h2, 32'h2);
    wait_idle();
    @(posedge i_mclk);
    strap_open <= 1'b0;
    rd_two(8'hFF, 8'hFF, 8'hFF);
    give_verdict();
  end

  // watchdog well beyond the expected run time
  initial
  begin
    #300000;
    err_total++;
    give_verdict();
  end
endmodule // tb_sep_core
